// >>> rtl/bac_pkg.sv
// Package: register map, field positions and reset values of the
// boost control configuration register.
// Assumes an 8-bit register access port inside the device.
package bac_pkg;
    localparam logic [7:0] BOOST_CONTROL_CONFIG_ADDR = 8'hA2;
    localparam logic [7:0] BOOST_CONTROL_CONFIG_RST = 8'hAE;
    localparam logic [7:0] CFG_USED_MASK = 8'hEE;
    localparam int ADAPT_FAST_BIT = 7;
    localparam int ADJUST_RATE_BIT = 6;
    localparam int SMOOTH_BIT = 5;
    localparam int ADAPT_EN_BIT = 3;
    localparam int BOOST_EN_BIT = 2;
    localparam int ILIM_BIT = 1;
    localparam logic [3:0] SLOW_DIVIDE = 4'hF;
    localparam logic [3:0] CNT_RST = 4'h0;
    typedef enum logic [1:0] {
        BAC_OFF = 2'b00,
        BAC_START = 2'b01,
        BAC_TRACK = 2'b11
    } bac_state_e;
endpackage

// >>> rtl/bac_cfg_if.sv
// Interface: configuration fields passed from the register to the
// boost control core.
// Assumes one clock domain.
`timescale 1ns/1ps
interface bac_cfg_if;
    logic [7:0] cfg;
    modport src (output cfg);
    modport dst (input cfg);
endinterface

// >>> rtl/bac_core.sv
// Boost control core: start-up, adaptive tracking and update pacing.
// Assumes the cycle strobe and reached flag are on the same clock.
`timescale 1ns/1ps
module bac_core (
    input wire logic clock,
    input wire logic rstn,
    bac_cfg_if.dst cfg_if,
    input wire logic backlight_en,
    input wire logic dim_cycle_done,
    input wire logic target_reached,
    output logic boost_on,
    output logic adaptive_tracking,
    output logic boost_update
);
    bac_pkg::bac_state_e state_reg, state_next;
    logic [3:0] cnt_reg, cnt_next;
    logic upd_next;
    logic on_next, track_next;

    ////////////////////////////////////////////////////////////////////
    // Next state and pacing
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        upd_next = 1'b0;
        unique case (state_reg)
            bac_pkg::BAC_OFF: begin
                if (cfg_if.cfg[bac_pkg::BOOST_EN_BIT] && backlight_en) begin
                    state_next = bac_pkg::BAC_START;
                end
            end
            bac_pkg::BAC_START: begin
                // Fixed mode stays on the target level until boost or backlight is disabled
                if (cfg_if.cfg[bac_pkg::ADAPT_EN_BIT] && target_reached) begin
                    state_next = bac_pkg::BAC_TRACK;
                end
            end
            bac_pkg::BAC_TRACK: begin
                if (!cfg_if.cfg[bac_pkg::ADAPT_EN_BIT]) begin
                    state_next = bac_pkg::BAC_START;
                end
            end
            default: state_next = bac_pkg::BAC_OFF;
        endcase
        if (!(cfg_if.cfg[bac_pkg::BOOST_EN_BIT] && backlight_en)) begin
            state_next = bac_pkg::BAC_OFF;
        end
        // Update once per dimming cycle, or every 16th one
        if (state_reg == bac_pkg::BAC_TRACK && dim_cycle_done) begin
            if (!cfg_if.cfg[bac_pkg::ADJUST_RATE_BIT]) begin
                upd_next = 1'b1;
                cnt_next = bac_pkg::CNT_RST;
            end else if (cnt_reg == bac_pkg::SLOW_DIVIDE) begin
                upd_next = 1'b1;
                cnt_next = bac_pkg::CNT_RST;
            end else begin
                cnt_next = cnt_reg + 4'h1;
            end
        end
        if (state_reg != bac_pkg::BAC_TRACK) begin
            cnt_next = bac_pkg::CNT_RST;
        end
        // Status levels follow the state that is about to be taken
        on_next = state_next != bac_pkg::BAC_OFF;
        track_next = state_next == bac_pkg::BAC_TRACK;
    end

    // Registered outputs
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_reg <= bac_pkg::BAC_OFF;
            cnt_reg <= bac_pkg::CNT_RST;
            boost_update <= 1'b0;
            boost_on <= 1'b0;
            adaptive_tracking <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            boost_update <= upd_next;
            boost_on <= on_next;
            adaptive_tracking <= track_next;
        end
    end

    a_boost_off: assert property (
        @(posedge clock) disable iff (!rstn)
        !cfg_if.cfg[bac_pkg::BOOST_EN_BIT] |=> !boost_on)
        else $error("boost on while disabled");
    a_fast_update: assert property (
        @(posedge clock) disable iff (!rstn)
        (state_reg == bac_pkg::BAC_TRACK && dim_cycle_done
         && !cfg_if.cfg[bac_pkg::ADJUST_RATE_BIT]) |=> boost_update)
        else $error("missed per cycle update");
    a_slow_update: assert property (
        @(posedge clock) disable iff (!rstn)
        (boost_update && $past(cfg_if.cfg[bac_pkg::ADJUST_RATE_BIT]))
        |-> $past(cnt_reg) == bac_pkg::SLOW_DIVIDE)
        else $error("slow update too early");
    a_fixed_mode: assert property (
        @(posedge clock) disable iff (!rstn)
        !cfg_if.cfg[bac_pkg::ADAPT_EN_BIT] |=> !adaptive_tracking)
        else $error("tracking in fixed mode");
endmodule

// >>> rtl/bac_top.sv
// Top: boost control configuration register and its control outputs.
// Assumes a byte register port with one-cycle strobes on clock.
`timescale 1ns/1ps
module bac_top (
    input wire logic clock,
    input wire logic rstn,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic backlight_en,
    input wire logic dim_cycle_done,
    input wire logic target_reached,
    output logic boost_on,
    output logic adaptive_tracking,
    output logic boost_update,
    output logic adaptive_fast_mode,
    output logic smooth_dimming_curve,
    output logic inductor_current_limit
);
    logic [7:0] cfg_reg, cfg_next;
    logic [7:0] rdata_next;
    logic [4:0] seen_reg, seen_next;
    // Dimming cycles per update in the slow pacing mode
    localparam logic [4:0] SLOW_PULSES = {1'b0, bac_pkg::SLOW_DIVIDE} + 5'h01;
    bac_cfg_if cfg_bus ();

    ////////////////////////////////////////////////////////////////////
    // Register write and read path
    always_comb begin
        cfg_next = cfg_reg;
        rdata_next = reg_rdata;
        if (reg_wr && reg_addr == bac_pkg::BOOST_CONTROL_CONFIG_ADDR) begin
            cfg_next = reg_wdata & bac_pkg::CFG_USED_MASK;
        end
        if (reg_rd) begin
            // Unmapped addresses read zero
            rdata_next = (reg_addr == bac_pkg::BOOST_CONTROL_CONFIG_ADDR)
                ? cfg_reg : 8'h00;
        end
    end

    // Mode outputs are registered copies so they follow a write by one
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cfg_reg <= bac_pkg::BOOST_CONTROL_CONFIG_RST;
            reg_rdata <= 8'h00;
            // Start from the default word so they match cfg_reg at once
            adaptive_fast_mode <=
                bac_pkg::BOOST_CONTROL_CONFIG_RST[bac_pkg::ADAPT_FAST_BIT];
            smooth_dimming_curve <=
                bac_pkg::BOOST_CONTROL_CONFIG_RST[bac_pkg::SMOOTH_BIT];
            inductor_current_limit <=
                bac_pkg::BOOST_CONTROL_CONFIG_RST[bac_pkg::ILIM_BIT];
        end else begin
            cfg_reg <= cfg_next;
            reg_rdata <= rdata_next;
            adaptive_fast_mode <= cfg_next[bac_pkg::ADAPT_FAST_BIT];
            smooth_dimming_curve <= cfg_next[bac_pkg::SMOOTH_BIT];
            inductor_current_limit <= cfg_next[bac_pkg::ILIM_BIT];
        end
    end

    assign cfg_bus.cfg = cfg_reg;

    bac_core u_core (
        .clock(clock),
        .rstn(rstn),
        .cfg_if(cfg_bus),
        .backlight_en(backlight_en),
        .dim_cycle_done(dim_cycle_done),
        .target_reached(target_reached),
        .boost_on(boost_on),
        .adaptive_tracking(adaptive_tracking),
        .boost_update(boost_update)
    );

    ////////////////////////////////////////////////////////////////////
    // Shadow count of dimming cycles seen while tracking, kept apart
    // from the core so a pacing slip inside it is caught here
    always_comb begin
        seen_next = seen_reg;
        if (!adaptive_tracking) begin
            seen_next = {1'b0, bac_pkg::CNT_RST};
        end else if (boost_update) begin
            // The update trails its dimming cycle by one edge
            seen_next = {4'h0, dim_cycle_done};
        end else if (dim_cycle_done) begin
            seen_next = seen_reg + 5'h01;
        end
    end

    // Shadow count register
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            seen_reg <= {1'b0, bac_pkg::CNT_RST};
        end else begin
            seen_reg <= seen_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Register port and mode output checks
    a_unused_zero: assert property (
        @(posedge clock) disable iff (!rstn)
        (cfg_reg & ~bac_pkg::CFG_USED_MASK) == 8'h00)
        else $error("unused bits set");

    a_ilim_follow: assert property (
        @(posedge clock) disable iff (!rstn)
        inductor_current_limit == cfg_reg[bac_pkg::ILIM_BIT])
        else $error("current limit mismatch");

    a_speed_follow: assert property (
        @(posedge clock) disable iff (!rstn)
        adaptive_fast_mode == cfg_reg[bac_pkg::ADAPT_FAST_BIT])
        else $error("speed mode mismatch");

    a_slope_follow: assert property (
        @(posedge clock) disable iff (!rstn)
        smooth_dimming_curve == cfg_reg[bac_pkg::SMOOTH_BIT])
        else $error("slope mode mismatch");

    // A write to the config address lands, less the dead bits
    a_write_lands: assert property (
        @(posedge clock) disable iff (!rstn)
        (reg_wr && reg_addr == bac_pkg::BOOST_CONTROL_CONFIG_ADDR) |=>
        cfg_reg == ($past(reg_wdata) & bac_pkg::CFG_USED_MASK))
        else $error("config write lost");

    // Nothing but a config write may move the register
    a_write_other: assert property (
        @(posedge clock) disable iff (!rstn)
        !(reg_wr && reg_addr == bac_pkg::BOOST_CONTROL_CONFIG_ADDR)
        |=> $stable(cfg_reg))
        else $error("config changed without write");

    // Read returns the word held at the read edge
    a_read_cfg: assert property (
        @(posedge clock) disable iff (!rstn)
        (reg_rd && reg_addr == bac_pkg::BOOST_CONTROL_CONFIG_ADDR)
        |=> reg_rdata == $past(cfg_reg))
        else $error("config read wrong");

    // Unmapped addresses read as zero
    a_read_other: assert property (
        @(posedge clock) disable iff (!rstn)
        (reg_rd && reg_addr != bac_pkg::BOOST_CONTROL_CONFIG_ADDR)
        |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");

    // Read data stands until the next read
    a_rdata_hold: assert property (
        @(posedge clock) disable iff (!rstn)
        !reg_rd |=> $stable(reg_rdata))
        else $error("read data moved");

    a_rdata_unused: assert property (
        @(posedge clock) disable iff (!rstn)
        (reg_rdata & ~bac_pkg::CFG_USED_MASK) == 8'h00)
        else $error("dead bits read back");

    // Mode outputs only move after a write
    a_speed_on_write: assert property (
        @(posedge clock) disable iff (!rstn)
        $changed(adaptive_fast_mode) |-> $past(reg_wr))
        else $error("speed mode moved alone");

    a_slope_on_write: assert property (
        @(posedge clock) disable iff (!rstn)
        $changed(smooth_dimming_curve) |-> $past(reg_wr))
        else $error("slope mode moved alone");

    a_ilim_on_write: assert property (
        @(posedge clock) disable iff (!rstn)
        $changed(inductor_current_limit) |-> $past(reg_wr))
        else $error("current limit moved alone");

    ////////////////////////////////////////////////////////////////////
    // Converter control checks
    a_auto_start: assert property (
        @(posedge clock) disable iff (!rstn)
        (cfg_reg[bac_pkg::BOOST_EN_BIT] && backlight_en) |=> boost_on)
        else $error("boost did not start");

    a_light_off: assert property (
        @(posedge clock) disable iff (!rstn)
        !backlight_en |=> !boost_on)
        else $error("boost on without backlight");

    a_track_boost: assert property (
        @(posedge clock) disable iff (!rstn)
        adaptive_tracking |-> boost_on)
        else $error("tracking while boost off");

    // Start-up always begins at the target level
    a_start_first: assert property (
        @(posedge clock) disable iff (!rstn)
        $rose(boost_on) |-> !adaptive_tracking)
        else $error("boost skipped start phase");

    a_track_entry: assert property (
        @(posedge clock) disable iff (!rstn)
        $rose(adaptive_tracking) |-> $past(target_reached)
        && $past(cfg_reg[bac_pkg::ADAPT_EN_BIT]))
        else $error("tracking entered too soon");

    // Fixed mode keeps regulating to the target level
    a_fixed_hold: assert property (
        @(posedge clock) disable iff (!rstn)
        (boost_on && !adaptive_tracking && !cfg_reg[bac_pkg::ADAPT_EN_BIT]
         && cfg_reg[bac_pkg::BOOST_EN_BIT] && backlight_en)
        |=> boost_on && !adaptive_tracking)
        else $error("fixed mode left start phase");

    a_track_leave: assert property (
        @(posedge clock) disable iff (!rstn)
        $fell(adaptive_tracking) |-> !$past(cfg_reg[bac_pkg::ADAPT_EN_BIT])
        || !$past(cfg_reg[bac_pkg::BOOST_EN_BIT]) || !$past(backlight_en))
        else $error("tracking dropped without cause");

    a_update_track: assert property (
        @(posedge clock) disable iff (!rstn)
        boost_update |-> $past(dim_cycle_done) && $past(adaptive_tracking))
        else $error("update outside tracking cycle");

    a_no_update_off: assert property (
        @(posedge clock) disable iff (!rstn)
        !adaptive_tracking |=> !boost_update)
        else $error("update while not tracking");

    // Slow pacing updates on exactly the sixteenth cycle
    a_slow_pace: assert property (
        @(posedge clock) disable iff (!rstn)
        (boost_update && $past(cfg_reg[bac_pkg::ADJUST_RATE_BIT]))
        |-> seen_reg == SLOW_PULSES)
        else $error("slow update off count");

    // A missed sixteenth update would push the shadow past its end
    a_slow_bound: assert property (
        @(posedge clock) disable iff (!rstn)
        seen_reg <= SLOW_PULSES)
        else $error("slow update missed");
endmodule

// >>> tb/tb_top.sv
// Testbench for the boost control configuration block.
// Assumes bac_top and bac_pkg are compiled first; drives on falling edge.
`timescale 1ns/1ps
module tb_top;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic reg_wr = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic backlight_en = 1'b0;
    logic dim_cycle_done = 1'b0;
    logic target_reached = 1'b0;
    logic boost_on, adaptive_tracking, boost_update;
    logic adaptive_fast_mode, smooth_dimming_curve, inductor_current_limit;
    int num_errors = 0;
    int n_compared = 0;
    int n_upd = 0;
    bac_top dut (.clock(clock), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .backlight_en(backlight_en),
        .dim_cycle_done(dim_cycle_done), .target_reached(target_reached),
        .boost_on(boost_on), .adaptive_tracking(adaptive_tracking),
        .boost_update(boost_update), .adaptive_fast_mode(adaptive_fast_mode),
        .smooth_dimming_curve(smooth_dimming_curve),
        .inductor_current_limit(inductor_current_limit));
    ////////////////////////////////////////////////////////////////////////
    // Clock and update pulse counter
    initial begin
        forever #5 clock = ~clock;
    end
    always @(negedge clock) begin
        if (boost_update === 1'b1) n_upd++; // Mid-cycle, where it is settled
    end
    ////////////////////////////////////////////////////////////////////////
    // Access and checking tasks
    task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(negedge clock);
        reg_addr = a; reg_wdata = d; reg_wr = 1'b1;
        @(negedge clock);
        reg_wr = 1'b0;
    endtask
    // Data lands at the read edge and holds, so sampling a cycle later is safe
    task automatic rd(logic [7:0] a, output logic [7:0] d);
        @(negedge clock);
        reg_addr = a; reg_rd = 1'b1;
        @(negedge clock);
        reg_rd = 1'b0;
        @(negedge clock);
        d = reg_rdata;
    endtask
    task automatic pulses(int n);
        repeat (n) begin
            @(negedge clock); dim_cycle_done = 1'b1;
            @(negedge clock); dim_cycle_done = 1'b0;
            repeat (2) @(negedge clock);
        end
    endtask
    task automatic report_and_stop();
        $display("Compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Watchdog: a hang counts as a mismatch
    initial begin
        #200us;
        num_errors++;
        report_and_stop();
    end
    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        logic [7:0] v;
        repeat (5) @(negedge clock);
        rstn = 1'b1;
        rd(bac_pkg::BOOST_CONTROL_CONFIG_ADDR, v);
        chk("reset value", v, 8'hAE);
        chk("fast mode", {7'h00, adaptive_fast_mode}, 8'h01);
        chk("smooth", {7'h00, smooth_dimming_curve}, 8'h01);
        chk("ilim", {7'h00, inductor_current_limit}, 8'h01);
        $display("Test reset done");
        wr(8'hA2, 8'hFF);
        rd(8'hA2, v);
        chk("unused bits", v, 8'hEE);
        wr(8'hA2, 8'h00);
        wr(8'hA5, 8'hFF);
        rd(8'hA2, v);
        chk("cleared cfg", v, 8'h00);
        chk("modes off", {adaptive_fast_mode, smooth_dimming_curve,
            inductor_current_limit}, 8'h00);
        rd(8'hA5, v);
        chk("unmapped read", v, 8'h00);
        $display("Test register done");
        backlight_en = 1'b1; target_reached = 1'b1;
        wr(8'hA2, 8'h0A);
        repeat (4) @(negedge clock);
        chk("boost disabled", {7'h00, boost_on}, 8'h00);
        wr(8'hA2, 8'h06);
        repeat (4) @(negedge clock);
        chk("boost auto", {7'h00, boost_on}, 8'h01);
        chk("fixed mode", {7'h00, adaptive_tracking}, 8'h00);
        wr(8'hA2, 8'h0E);
        repeat (4) @(negedge clock);
        chk("tracking", {7'h00, adaptive_tracking}, 8'h01);
        n_upd = 0;
        pulses(3);
        chk("every cycle", n_upd[7:0], 8'h03);
        $display("Test boost done");
        backlight_en = 1'b0;
        repeat (2) @(negedge clock);
        chk("boost off", {7'h00, boost_on}, 8'h00);
        wr(8'hA2, 8'h4E);
        backlight_en = 1'b1;
        repeat (4) @(negedge clock);
        n_upd = 0;
        pulses(15);
        chk("before 16th", n_upd[7:0], 8'h00);
        pulses(1);
        chk("16th cycle", n_upd[7:0], 8'h01);
        $display("Test rate done");
        report_and_stop();
    end
endmodule
